// >>> rtl/period_match_timer_8bit.sv
`timescale 1ns/1ps
`default_nettype none

module period_match_timer_8bit (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             irq,
    output logic             pwm_match,
    output logic             gate_pulse,
    output logic             spi_shift_clock
);
    import period_timer_pkg::*;

    timer_period_control_t ctrl;
    logic [7:0]            period_count;
    logic [7:0]            period_limit;
    logic [1:0]            phase;
    logic [3:0]            pre_cnt;
    logic [3:0]            post_cnt;
    logic [1:0]            gate_cnt;
    logic                  match_irq_flag;
    logic                  match_irq_enable;
    logic                  wr_ok;
    logic                  rd_ok;
    logic                  cnt_wr;
    logic                  lim_wr;
    logic                  ctrl_wr;
    logic                  mask_wr;
    logic                  stat_rd;
    logic                  scaler_clr;
    logic                  q_tick;
    logic                  timer_tick;
    logic                  hit;
    logic                  post_done;
    logic [3:0]            pre_last;
    logic [31:0]           next_readdata;

    // Accepted transfers: the edge where waitrequest is seen low
    assign wr_ok   = write & ~waitrequest & byteenable[0];
    assign rd_ok   = read & ~waitrequest;
    assign cnt_wr  = wr_ok && (address == OFS_COUNT);
    assign lim_wr  = wr_ok && (address == OFS_LIMIT);
    assign ctrl_wr = wr_ok && (address == OFS_CTRL);
    assign mask_wr = wr_ok && (address == OFS_MASK);
    assign stat_rd = rd_ok && (address == OFS_STATUS);

    // Both writes restart the scalers; a tick in that cycle is dropped
    assign scaler_clr = cnt_wr | ctrl_wr;

    // Instruction-cycle tick only while the timer is on
    assign q_tick = ctrl.timer_run && (phase == PHASE_LAST);

    // Last prescaler count for the selected ratio
    always_comb begin
        case (ctrl.prescale_select)
            PRE_SEL_1: pre_last = PRE_LAST_1;
            PRE_SEL_4: pre_last = PRE_LAST_4;
            default:   pre_last = PRE_LAST_16;
        endcase
    end

    // Timer clock, comparator and postscaler terminal count
    assign timer_tick = q_tick && (pre_cnt == pre_last) && !scaler_clr;
    assign hit        = timer_tick && (period_count == period_limit);
    assign post_done  = hit && (post_cnt == ctrl.postscale_select);

    // Read mux, unmapped offsets read zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (address)
            OFS_COUNT:  next_readdata[7:0] = period_count;
            OFS_LIMIT:  next_readdata[7:0] = period_limit;
            OFS_CTRL:   next_readdata[CTRL_WIDTH-1:0] = ctrl;
            OFS_STATUS: next_readdata[STAT_MATCH_BIT] = match_irq_flag;
            OFS_MASK:   next_readdata[STAT_MATCH_BIT] = match_irq_enable;
            default:    next_readdata = 32'h0000_0000;
        endcase
    end

    // One wait cycle per request, then one accept cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~((read | write) & waitrequest);
        end
    end

    // Read data captured one edge ahead so it stands at the accept edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= next_readdata;
        end
    end

    // Instruction-cycle phase, frozen while off to save power
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 2'h0;
        end else if (ctrl.timer_run) begin
            phase <= phase + 2'h1;
        end
    end

    // Control register; top bit never stored
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl <= timer_period_control_t'(writedata[CTRL_WIDTH-1:0]);
        end
    end

    // Prescaler
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pre_cnt <= 4'h0;
        end else if (scaler_clr) begin
            pre_cnt <= 4'h0;
        end else if (q_tick) begin
            pre_cnt <= (pre_cnt == pre_last) ? 4'h0 : pre_cnt + 4'h1;
        end
    end

    // Count register; a control write never touches it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            period_count <= COUNT_RESET;
        end else if (cnt_wr) begin
            period_count <= writedata[7:0];
        end else if (timer_tick) begin
            period_count <= hit ? 8'h00 : period_count + 8'h01;
        end
    end

    // Period register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            period_limit <= LIMIT_RESET;
        end else if (lim_wr) begin
            period_limit <= writedata[7:0];
        end
    end

    // Postscaler, clocked by matches only
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            post_cnt <= 4'h0;
        end else if (scaler_clr) begin
            post_cnt <= 4'h0;
        end else if (hit) begin
            post_cnt <= post_done ? 4'h0 : post_cnt + 4'h1;
        end
    end

    // Sticky flag; only a bit that was actually returned is cleared,
    // so an event landing between capture and accept is kept
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            match_irq_flag <= 1'b0;
        end else begin
            match_irq_flag <= post_done |
                (match_irq_flag & ~(stat_rd & readdata[STAT_MATCH_BIT]));
        end
    end

    // Interrupt enable
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            match_irq_enable <= 1'b0;
        end else if (mask_wr) begin
            match_irq_enable <= writedata[STAT_MATCH_BIT];
        end
    end

    // Level interrupt, one cycle behind the flag
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= match_irq_flag & match_irq_enable;
        end
    end

    // Unscaled match and serial shift clock
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pwm_match       <= 1'b0;
            spi_shift_clock <= 1'b0;
        end else begin
            pwm_match <= hit;
            if (hit) begin
                spi_shift_clock <= ~spi_shift_clock;
            end
        end
    end

    // Gate pulse: one instruction cycle long; matches are at least
    // one instruction cycle apart so a pulse never overlaps the next
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gate_pulse <= 1'b0;
            gate_cnt   <= 2'h0;
        end else if (hit) begin
            gate_pulse <= 1'b1;
            gate_cnt   <= GATE_LAST;
        end else if (gate_cnt != 2'h0) begin
            gate_cnt <= gate_cnt - 2'h1;
        end else begin
            gate_pulse <= 1'b0;
        end
    end

    // Checks

    a_match_wrap: assert property (@(posedge clock) disable iff (!rst_b)
        hit |=> (period_count == 8'h00) && pwm_match)
        else $error("count did not wrap on match");

    a_count_step: assert property (@(posedge clock) disable iff (!rst_b)
        (timer_tick && !hit && !cnt_wr) |=> (period_count == $past(period_count) + 8'h01))
        else $error("count did not advance by one");

    a_pre_div: assert property (@(posedge clock) disable iff (!rst_b)
        (timer_tick && ctrl.prescale_select == PRE_SEL_4 && !ctrl_wr && !cnt_wr)
        |=> !timer_tick [*8] ##1 !timer_tick [*4])
        else $error("divide by four ticks too early");

    a_post_flag: assert property (@(posedge clock) disable iff (!rst_b)
        post_done |=> match_irq_flag && (post_cnt == 4'h0))
        else $error("postscaler completion lost");

    a_clear_scaler: assert property (@(posedge clock) disable iff (!rst_b)
        scaler_clr |=> (pre_cnt == 4'h0) && (post_cnt == 4'h0))
        else $error("scalers not cleared by write");

    a_ctrl_keep: assert property (@(posedge clock) disable iff (!rst_b)
        ctrl_wr |=> $stable(period_count))
        else $error("control write changed count");

    a_off_hold: assert property (@(posedge clock) disable iff (!rst_b)
        (!ctrl.timer_run && !cnt_wr) |=> $stable(period_count) && !pwm_match
        && $stable(post_cnt))
        else $error("timer moved while off");

    a_gate_width: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(gate_pulse) |-> gate_pulse [*4] ##1 !gate_pulse)
        else $error("gate pulse not one instruction cycle");

    a_irq_level: assert property (@(posedge clock) disable iff (!rst_b)
        (match_irq_flag && match_irq_enable) |=> irq)
        else $error("enabled flag gave no interrupt");

    a_ctrl_top: assert property (@(posedge clock) disable iff (!rst_b)
        (rd_ok && address == OFS_CTRL) |-> (readdata[31:7] == 25'h0))
        else $error("control top bit read non-zero");

    a_reset_vals: assert property (@(posedge clock)
        $rose(rst_b) |-> (period_limit == LIMIT_RESET) && (period_count == COUNT_RESET))
        else $error("wrong reset values");

endmodule

`default_nettype wire

// >>> inc/period_timer_pkg.sv
`default_nettype none

package period_timer_pkg;

    // Register byte offsets on the slave bus
    localparam logic [4:0] OFS_COUNT  = 5'h00;
    localparam logic [4:0] OFS_LIMIT  = 5'h04;
    localparam logic [4:0] OFS_CTRL   = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0C;
    localparam logic [4:0] OFS_MASK   = 5'h10;

    // Values after reset
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] LIMIT_RESET = 8'hFF;

    // Instruction cycle is four system clocks
    localparam int         INSTR_DIV  = 4;
    localparam logic [1:0] PHASE_LAST = 2'(INSTR_DIV - 1);
    localparam logic [1:0] GATE_LAST  = 2'(INSTR_DIV - 1);

    // Prescale select codes and the last prescaler count for each
    localparam logic [1:0] PRE_SEL_1  = 2'h0;
    localparam logic [1:0] PRE_SEL_4  = 2'h1;
    localparam logic [3:0] PRE_LAST_1  = 4'h0;
    localparam logic [3:0] PRE_LAST_4  = 4'h3;
    localparam logic [3:0] PRE_LAST_16 = 4'hF;

    // Field positions
    localparam int CTRL_WIDTH     = 7;
    localparam int STAT_MATCH_BIT = 0;

    // Control register layout, bit 7 is not stored
    typedef struct packed {
        logic [3:0] postscale_select;
        logic       timer_run;
        logic [1:0] prescale_select;
    } timer_period_control_t;

    localparam timer_period_control_t CTRL_RESET = '0;

endpackage

`default_nettype wire

// >>> sim/time_base_model.sv
`timescale 1ns/1ps
`default_nettype none

module time_base_model (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        pwm_match,
    input  wire logic        gate_pulse,
    input  wire logic        spi_shift_clock,
    output logic      [15:0] match_total,
    output logic      [15:0] toggle_total,
    output logic      [7:0]  gate_width
);
    logic [7:0] run_len;
    logic       spi_last;

    // PWM time base counts every unscaled period end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            match_total <= 16'h0000;
        end else if (pwm_match) begin
            match_total <= match_total + 16'h0001;
        end
    end

    // Gate logic keeps the width of the last pulse it saw
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run_len    <= 8'h00;
            gate_width <= 8'h00;
        end else if (gate_pulse) begin
            run_len <= run_len + 8'h01;
        end else begin
            if (run_len != 8'h00) gate_width <= run_len;
            run_len <= 8'h00;
        end
    end

    // Serial port sees one shift clock edge per period
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            spi_last     <= 1'b0;
            toggle_total <= 16'h0000;
        end else begin
            spi_last <= spi_shift_clock;
            if (spi_shift_clock != spi_last) toggle_total <= toggle_total + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED time=%0t got %0h expected %0h", $time, g, e); end end

module testbench;
    import period_timer_pkg::*;

    logic        clock, rst_b, read, write, waitrequest, irq, pwm_match, gate_pulse, spi_clk;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata, readdata, q;
    logic [15:0] match_total, toggle_total, m0;
    logic [7:0]  gate_width;
    int          num_errors, num_checks, cycles, n;
    int          ps_list[3] = '{0, 2, 15};

    period_match_timer_8bit DUT (.clock(clock), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .pwm_match(pwm_match), .gate_pulse(gate_pulse),
        .spi_shift_clock(spi_clk));

    time_base_model far_side (.clock(clock), .rst_b(rst_b), .pwm_match(pwm_match),
        .gate_pulse(gate_pulse), .spi_shift_clock(spi_clk), .match_total(match_total),
        .toggle_total(toggle_total), .gate_width(gate_width));

    // One transfer; held until waitrequest is sampled low
    task automatic bus(input logic [4:0] a, input logic rd, input logic [7:0] d,
                       input logic [3:0] be);
        @(posedge clock);
        address    <= a;
        read       <= rd;
        write      <= !rd;
        writedata  <= {24'h000000, d};
        byteenable <= be;
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(a, 1'b0, d, 4'hF);
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        bus(a, 1'b1, 8'h00, 4'h0);
        `CHK(q, 32'(e))
    endtask

    task automatic wait_match();
        do @(posedge clock); while (pwm_match !== 1'b1);
    endtask

    // Irq must drop first, else a stale flag looks like a new one
    task automatic wait_irq_rise();
        while (irq !== 1'b0) @(posedge clock);
        while (irq !== 1'b1) @(posedge clock);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic t_reset();
        rd_chk(OFS_COUNT, 8'h00);
        rd_chk(OFS_LIMIT, 8'hFF);
        rd_chk(OFS_CTRL, 8'h00);
        `CHK(irq, 1'b0)
        $display("reset values done");
    endtask

    // Timer off throughout, so nothing may move the count
    task automatic t_regs();
        wr(OFS_LIMIT, 8'h5A);
        rd_chk(OFS_LIMIT, 8'h5A);
        bus(OFS_LIMIT, 1'b0, 8'h11, 4'h0);
        rd_chk(OFS_LIMIT, 8'h5A);
        wr(OFS_COUNT, 8'h33);
        wr(OFS_CTRL, 8'hFB);
        rd_chk(OFS_CTRL, 8'h7B);
        rd_chk(5'h14, 8'h00);
        repeat (40) @(posedge clock);
        rd_chk(OFS_COUNT, 8'h33);
        `CHK(match_total, 16'h0000)
        $display("register access done");
    endtask

    // Period 4 counts: 4 clocks x prescale x 4 between matches
    task automatic t_prescale();
        wr(OFS_LIMIT, 8'h03);
        wr(OFS_COUNT, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(OFS_CTRL, 8'h04 | 8'(c));
            wait_match();
            wait_match();
            n = 0;
            do begin @(posedge clock); n++; end while (pwm_match !== 1'b1);
            `CHK(n, 16 * (c == 0 ? 1 : (c == 1 ? 4 : 16)))
            `CHK(gate_width, 8'h04)
        end
        $display("prescale done");
    endtask

    task automatic t_postscale();
        wr(OFS_MASK, 8'h01);
        foreach (ps_list[i]) begin
            wr(OFS_CTRL, 8'(ps_list[i] << 3) | 8'h04);
            bus(OFS_STATUS, 1'b1, 8'h00, 4'h0);
            wait_irq_rise();
            m0 = match_total;
            rd_chk(OFS_STATUS, 8'h01);
            wait_irq_rise();
            `CHK(match_total - m0, 16'(ps_list[i] + 1))
        end
        wr(OFS_MASK, 8'h00);
        // Back to 1:1 so each of the two matches below sets the flag
        wr(OFS_CTRL, 8'h04);
        bus(OFS_STATUS, 1'b1, 8'h00, 4'h0);
        wait_match();
        wait_match();
        repeat (3) @(posedge clock);
        `CHK(irq, 1'b0)
        rd_chk(OFS_STATUS, 8'h01);
        wr(OFS_CTRL, 8'h00);
        repeat (20) @(posedge clock);
        `CHK(toggle_total, match_total)
        $display("postscale and interrupt done");
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Ceiling well above the longest scenario
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    initial begin
        rst_b      = 1'b0;
        read       = 1'b0;
        write      = 1'b0;
        address    = 5'h00;
        writedata  = 32'h00000000;
        byteenable = 4'h0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_regs();
        t_prescale();
        t_postscale();
        close_out();
    end
endmodule
`default_nettype wire
